// >>> shared/cfg_pin_map.svh
`ifndef CFG_PIN_MAP_SVH
`define CFG_PIN_MAP_SVH

// Mode pin codes
`define MODE_MASTER_SERIAL 3'h0
`define MODE_MASTER_SPI 3'h1
`define MODE_MASTER_PFLASH 3'h2
`define MODE_MASTER_PORT 3'h4
`define MODE_BOUNDARY_ONLY 3'h5
`define MODE_SLAVE_PORT 3'h6
`define MODE_SLAVE_SERIAL 3'h7

// APB register offsets
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_PINMAP 12'h008

// Control field positions
`define CTRL_KEEP_ACTIVE 0
`define CTRL_EXT_CLK_EN 1
`define CTRL_DEBUG_IMAGE 2
`define CTRL_FALLBACK_EN 3
`define CTRL_DAISY_CHAIN 4
`define CTRL_DONE 5
`define CTRL_DIV_LSB 8
`define CTRL_DIV_MSB 15
`define CTRL_RESET 32'h0000_0400

// Revision select hold time in ns, converted to 10 ns sys_clk cycles (own choice)
`define REVSEL_HOLD_NS 320
`define REVSEL_HOLD_CYC (`REVSEL_HOLD_NS / 10)

`endif

// >>> shared/cfg_pin_pkg.sv
package cfg_pin_pkg;
   typedef enum logic [2:0] {
      MASTER_SERIAL = 3'b000,
      MASTER_SPI = 3'b001,
      MASTER_PFLASH = 3'b010,
      MASTER_PORT = 3'b100,
      BOUNDARY_ONLY = 3'b101,
      SLAVE_PORT = 3'b110,
      SLAVE_SERIAL = 3'b111
   } cfgMode_t;

   typedef enum logic [1:0] {
      ST_LOAD = 2'b00,
      ST_USER = 2'b01
   } phase_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apbReq_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apbRsp_t;

   typedef struct packed {
      logic flashSelect;
      logic readWriteDir;
      logic serialData;
      logic dataLow;
      logic dataHigh;
      logic dataWide;
      logic address;
      logic addressValid;
      logic chipSelectIn;
      logic flashOutEnable;
      logic flashWriteEnable;
      logic secondFlashSelect;
      logic extClockUse;
      logic masterClock;
   } pinUse_t;
endpackage : cfg_pin_pkg

// >>> design/sync_3ff.sv
`timescale 1ns/1ps
module sync_3ff #(
   parameter int WIDTH = 1
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] asyncIn,
   input wire logic [WIDTH-1:0] resetVal,
   output logic [WIDTH-1:0] syncOut
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] q;
   } state_t;

   state_t st;
   state_t next_st;

   // A change counts once the second and third stages agree
   always_comb begin
      next_st = st;
      next_st.s1 = asyncIn;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int i = 0; i < WIDTH; i++) begin
         if (st.s2[i] == st.s3[i]) begin
            next_st.q[i] = st.s3[i];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         st <= '{s1: resetVal, s2: resetVal, s3: resetVal, q: resetVal};
      end else begin
         st <= next_st;
      end
   end

   assign syncOut = st.q;
endmodule : sync_3ff

// >>> design/config_pin_mode_mux.sv
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
`include "cfg_pin_map.svh"
// Operation
// [R1] Program, init, done, clock and test pins work in every mode.
// [R2] Keep-active leaves the mode's multi-function pins as configuration pins after done.
// [R3] External master clock used only for master modes with its enable set.
// [R4] Serial data-out driven only in serial daisy chain or debug image.
// [R5] Downstream chip enable driven only in parallel daisy chain.
// [R6] Revision select driven only in parallel flash on reload or fallback.
// [R7] Pins unused by the mode are high-impedance and their inputs ignored.
// [R8] Mode pins decode shared pin functions such as flash select versus direction.
// [R9] Boundary-scan configuration is available in every mode.
// [R10] Undriven mode pins select slave serial through pull-ups.
module config_pin_mode_mux (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire cfg_pin_pkg::apbReq_t apbReq,
   output cfg_pin_pkg::apbRsp_t apbRsp,
   input wire logic [2:0] modePins,
   input wire logic ext_master_config_clock,
   input wire logic reloadStart,
   input wire logic fallbackEvent,
   input wire logic [1:0] revisionValue,
   input wire logic coreSerialOut,
   input wire logic coreFlashSelect_n,
   input wire logic coreNextSelect_n,
   input wire logic config_clock_i,
   output logic config_clock_o,
   output logic config_clock_oe,
   input wire logic rdwr_or_flash_select_n_i,
   output logic rdwr_or_flash_select_n_o,
   output logic rdwr_or_flash_select_n_oe,
   output logic serialDataOut,
   output logic serialDataOutEn,
   output logic downstream_chip_enable_n,
   output logic downstreamChipEnableEn,
   output logic [1:0] revision_select,
   output logic revisionSelectEn,
   output logic read_write_dir_n,
   output logic boundaryScanEnable,
   output logic dedicatedPinsEnable,
   output logic extClockSelected,
   output cfg_pin_pkg::pinUse_t pinUse
);
   import cfg_pin_pkg::*;

   typedef struct packed {
      logic [31:0] ctrl;
      logic [2:0] modeLatch;
      logic modeValid;
      logic [2:0] settleCnt;
      phase_t phase;
      logic [7:0] divCnt;
      logic clkOut;
      logic [15:0] revHold;
      logic [1:0] revValue;
      logic serOut;
      logic nextSel;
      logic flashSel;
      logic dirIn;
      apbRsp_t rsp;
   } state_t;

   state_t st;
   state_t next_st;
   logic [2:0] modeSync;
   logic clkInSync;
   logic rdwrSync;
   logic extClkSync;
   cfgMode_t mode;
   pinUse_t use_;
   logic isMaster;
   logic active;

   // ==========================================
   // Pin input synchronisers
   // ==========================================
   // Mode pins reset high to match the internal pull-ups
   sync_3ff #(.WIDTH(6)) u_sync (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .asyncIn({modePins, config_clock_i, rdwr_or_flash_select_n_i, ext_master_config_clock}),
      .resetVal(6'h38),
      .syncOut({modeSync, clkInSync, rdwrSync, extClkSync})
   ); // [R10]

   assign mode = cfgMode_t'(st.modeLatch);
   assign isMaster = (mode == MASTER_SERIAL) || (mode == MASTER_SPI) ||
                     (mode == MASTER_PFLASH) || (mode == MASTER_PORT);
   // Pins stay configuration pins while loading, or afterwards if kept active
   assign active = (st.phase == ST_LOAD) || st.ctrl[`CTRL_KEEP_ACTIVE]; // [R2]

   // ==========================================
   // Mode decode
   // ==========================================
   always_comb begin
      use_ = '0;
      case (mode)
         MASTER_SERIAL: begin
            use_.serialData = 1'b1;
            use_.extClockUse = 1'b1;
            use_.masterClock = 1'b1;
         end
         MASTER_SPI: begin
            use_.flashSelect = 1'b1; // [R8]
            use_.serialData = 1'b1;
            use_.dataLow = 1'b1;
            use_.secondFlashSelect = 1'b1;
            use_.extClockUse = 1'b1;
            use_.masterClock = 1'b1;
         end
         MASTER_PFLASH: begin
            use_.flashSelect = 1'b1; // [R8]
            use_.dataLow = 1'b1;
            use_.dataHigh = 1'b1;
            use_.address = 1'b1;
            use_.addressValid = 1'b1;
            use_.flashOutEnable = 1'b1;
            use_.flashWriteEnable = 1'b1;
            use_.extClockUse = 1'b1;
            use_.masterClock = 1'b1;
         end
         MASTER_PORT: begin
            use_.readWriteDir = 1'b1; // [R8]
            use_.dataLow = 1'b1;
            use_.dataHigh = 1'b1;
            use_.chipSelectIn = 1'b1;
            use_.extClockUse = 1'b1;
            use_.masterClock = 1'b1;
         end
         SLAVE_PORT: begin
            use_.readWriteDir = 1'b1; // [R8]
            use_.dataLow = 1'b1;
            use_.dataHigh = 1'b1;
            use_.dataWide = 1'b1;
            use_.chipSelectIn = 1'b1;
         end
         SLAVE_SERIAL: begin
            use_.serialData = 1'b1;
         end
         BOUNDARY_ONLY: begin
            use_ = '0;
         end
         default: begin
            use_ = '0;
         end
      endcase
      if (!active) begin
         use_ = '0; // [R7]
      end
   end

   // ==========================================
   // Next state
   // ==========================================
   always_comb begin
      next_st = st;
      next_st.rsp.pready = 1'b0;
      next_st.rsp.pslverr = 1'b0;
      // Mode is caught once, only after the pin synchroniser has settled past reset
      if (!st.modeValid) begin
         if (st.settleCnt == 3'h4) begin
            next_st.modeLatch = modeSync;
            next_st.modeValid = 1'b1;
         end else begin
            next_st.settleCnt = st.settleCnt + 3'h1;
         end
      end
      if (st.ctrl[`CTRL_DONE]) begin
         next_st.phase = ST_USER;
      end
      // Internal divider; external clock edge replaces it when enabled
      if (use_.masterClock && st.ctrl[`CTRL_EXT_CLK_EN]) begin
         next_st.clkOut = extClkSync; // [R3]
      end else if (st.divCnt == 8'h00) begin
         next_st.divCnt = st.ctrl[`CTRL_DIV_MSB:`CTRL_DIV_LSB];
         next_st.clkOut = ~st.clkOut; // [R3]
      end else begin
         next_st.divCnt = st.divCnt - 8'h01;
      end
      // Revision select latches on reload, or on fallback when enabled
      if (mode == MASTER_PFLASH &&
          (reloadStart || (fallbackEvent && st.ctrl[`CTRL_FALLBACK_EN]))) begin
         next_st.revHold = 16'(`REVSEL_HOLD_CYC);
         next_st.revValue = revisionValue; // [R6]
      end else if (st.revHold != 16'h0000) begin
         next_st.revHold = st.revHold - 16'h0001;
      end
      next_st.serOut = coreSerialOut;
      next_st.nextSel = coreNextSelect_n;
      next_st.flashSel = coreFlashSelect_n;
      // Unused pins are ignored: input captured only when used
      if (use_.readWriteDir) begin
         next_st.dirIn = rdwrSync; // [R7]
      end
      // Writes land at the edge that sees ready, never at the setup edge
      if (apbReq.psel && apbReq.penable && st.rsp.pready && apbReq.pwrite &&
          apbReq.paddr == `REG_CTRL) begin
         next_st.ctrl = apbReq.pwdata;
      end
      // Zero-wait APB slave: answer in the access cycle
      if (apbReq.psel && !apbReq.penable) begin
         next_st.rsp.pready = 1'b1;
         next_st.rsp.prdata = 32'h0000_0000;
         case (apbReq.paddr)
            `REG_CTRL: begin
               if (!apbReq.pwrite) begin
                  next_st.rsp.prdata = st.ctrl;
               end
            end
            `REG_STATUS: begin
               next_st.rsp.prdata = {26'h0, st.phase == ST_USER, extClockSelected, mode == cfgMode_t'(3'h7),
                                     st.modeLatch};
            end
            `REG_PINMAP: begin
               next_st.rsp.prdata = {18'h0, use_};
            end
            default: begin
               next_st.rsp.pslverr = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         st <= '0;
         st.ctrl <= `CTRL_RESET;
         st.modeLatch <= `MODE_SLAVE_SERIAL; // [R10]
         st.phase <= ST_LOAD;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================
   // Pin drivers
   // ==========================================
   assign apbRsp = st.rsp;
   assign extClockSelected = use_.masterClock && st.ctrl[`CTRL_EXT_CLK_EN]; // [R3]
   assign dedicatedPinsEnable = 1'b1; // [R1]
   assign boundaryScanEnable = 1'b1; // [R9]
   assign config_clock_o = st.clkOut;
   assign config_clock_oe = isMaster && (st.phase == ST_LOAD); // [R1]
   assign rdwr_or_flash_select_n_o = st.flashSel;
   assign rdwr_or_flash_select_n_oe = use_.flashSelect; // [R8]
   assign read_write_dir_n = st.dirIn;
   assign serialDataOut = st.serOut;
   assign serialDataOutEn = use_.serialData &&
                            (st.ctrl[`CTRL_DAISY_CHAIN] || st.ctrl[`CTRL_DEBUG_IMAGE]); // [R4]
   assign downstream_chip_enable_n = st.nextSel;
   assign downstreamChipEnableEn = (use_.dataLow && !use_.serialData && !use_.flashSelect ||
                                    mode == MASTER_PFLASH && active) &&
                                   st.ctrl[`CTRL_DAISY_CHAIN]; // [R5]
   assign revision_select = st.revValue;
   assign revisionSelectEn = (mode == MASTER_PFLASH) && (st.revHold != 16'h0000); // [R6]
   assign pinUse = use_;
endmodule : config_pin_mode_mux

// >>> bench/cfg_pin_monitor.sv
`timescale 1ns/1ps
`include "cfg_pin_map.svh"
module cfg_pin_monitor (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire cfg_pin_pkg::apbReq_t apbReq,
   input wire cfg_pin_pkg::apbRsp_t apbRsp,
   input wire logic serialDataOutEn,
   input wire logic downstreamChipEnableEn,
   input wire logic revisionSelectEn,
   input wire logic rdwr_or_flash_select_n_oe,
   input wire logic read_write_dir_n,
   input wire logic boundaryScanEnable,
   input wire logic dedicatedPinsEnable,
   input wire cfg_pin_pkg::pinUse_t pinUse
);
   import cfg_pin_pkg::*;
   int holdCnt;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // =====
   // Revision select hold counter
   always_ff @(posedge sys_clk) begin
      if (!rst_b || !revisionSelectEn) holdCnt <= 0;
      else holdCnt <= holdCnt + 1;
   end
   AST_DEDICATED: assert property (dedicatedPinsEnable)
      else $error("dedicated pins disabled");
   AST_BSCAN: assert property (boundaryScanEnable)
      else $error("boundary scan disabled");
   AST_ANSWER: assert property (apbReq.psel && !apbReq.penable |=> apbRsp.pready)
      else $error("no answer after setup");
   AST_PULSE: assert property (apbRsp.pready |=> !apbRsp.pready)
      else $error("ready longer than one cycle");
   AST_REVHOLD: assert property ($fell(revisionSelectEn) |-> holdCnt == `REVSEL_HOLD_CYC)
      else $error("revision select hold wrong");
   AST_REVMODE: assert property (revisionSelectEn |-> pinUse.address)
      else $error("revision select outside parallel flash");
   AST_DOUT: assert property (serialDataOutEn |-> pinUse.serialData)
      else $error("serial out driven outside serial mode");
   AST_CSO: assert property (downstreamChipEnableEn |-> pinUse.dataLow)
      else $error("chip enable driven outside parallel mode");
   AST_FCS: assert property (rdwr_or_flash_select_n_oe |-> pinUse.flashSelect && !pinUse.readWriteDir)
      else $error("shared pin driven in wrong role");
   AST_DIR: assert property (!pinUse.readWriteDir |=> $stable(read_write_dir_n))
      else $error("direction input not ignored");
   cover property (apbRsp.pready && apbRsp.pslverr);
   cover property ($rose(revisionSelectEn));
   cover property (serialDataOutEn && downstreamChipEnableEn == 1'b0);
endmodule : cfg_pin_monitor

// >>> bench/cfg_config_source.sv
`timescale 1ns/1ps
module cfg_config_source (
   input wire logic extRun,
   input wire logic dirLevel,
   input wire logic clkO,
   input wire logic clkOe,
   input wire logic selO,
   input wire logic selOe,
   output logic clkI,
   output logic selI,
   output logic extClk
);
   logic hostClk = 1'b0;
   // =====
   // Far side clocks stand still unless a load runs
   always #13 hostClk = extRun ? ~hostClk : 1'b0;
   always #7 extClk = extRun ? ~extClk : 1'b0;
   assign clkI = clkOe ? clkO : hostClk;
   assign selI = selOe ? selO : dirLevel;
endmodule : cfg_config_source

// >>> bench/config_pin_mode_mux_tb.sv
`timescale 1ns/1ps
`include "cfg_pin_map.svh"
module config_pin_mode_mux_tb;
   import cfg_pin_pkg::*;
   logic sys_clk = 0, rst_b = 0, reloadStart = 0, fallbackEvent = 0, extRun = 0, dirLevel = 0;
   logic coreSer = 1'b0, coreFs = 1'b1, coreNs = 1'b1;
   logic [2:0] modePins = 3'h7;
   logic [1:0] revisionValue = 2'h0;
   apbReq_t apbReq = '0;
   apbRsp_t apbRsp;
   pinUse_t pinUse;
   logic clkI, clkO, clkOe, selI, selO, selOe, extClk, sdo, sdoEn, dce, dceEn, revEn, rwDir, bsEn, dpEn, extSel;
   logic [1:0] revSel;
   logic [33:0] expQ[$];
   logic [33:0] ex;
   int n_fail = 0, comparisons = 0;
   always #5 sys_clk = ~sys_clk;
   config_pin_mode_mux DUT (.sys_clk(sys_clk), .rst_b(rst_b), .apbReq(apbReq), .apbRsp(apbRsp),
      .modePins(modePins), .ext_master_config_clock(extClk), .reloadStart(reloadStart),
      .fallbackEvent(fallbackEvent), .revisionValue(revisionValue), .coreSerialOut(coreSer),
      .coreFlashSelect_n(coreFs), .coreNextSelect_n(coreNs), .config_clock_i(clkI), .config_clock_o(clkO),
      .config_clock_oe(clkOe), .rdwr_or_flash_select_n_i(selI), .rdwr_or_flash_select_n_o(selO),
      .rdwr_or_flash_select_n_oe(selOe), .serialDataOut(sdo), .serialDataOutEn(sdoEn),
      .downstream_chip_enable_n(dce), .downstreamChipEnableEn(dceEn), .revision_select(revSel),
      .revisionSelectEn(revEn), .read_write_dir_n(rwDir), .boundaryScanEnable(bsEn),
      .dedicatedPinsEnable(dpEn), .extClockSelected(extSel), .pinUse(pinUse));
   cfg_config_source SRC (.extRun(extRun), .dirLevel(dirLevel), .clkO(clkO), .clkOe(clkOe), .selO(selO),
      .selOe(selOe), .clkI(clkI), .selI(selI), .extClk(extClk));
   // =====
   // Checks and bus cycles
   task results;
      $display("Comparisons %0d, errors %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : results
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e);
      int n;
      n = 0;
      expQ.push_back(e);
      apbReq <= '{1'b1, 1'b0, w, a, d};
      @(posedge sys_clk);
      apbReq.penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (apbRsp.pready !== 1'b1 && n < 20);
      apbReq <= '0;
      if (apbRsp.pready !== 1'b1) begin
         n_fail++;
         $display("Error %0t: no ready from slave", $time);
         results();
      end
      // One idle edge so the next request never overwrites this release
      @(posedge sys_clk);
   endtask : apb
   // Edges between two changes of the config clock output, after the next change
   task half(input int e);
      int n;
      logic c;
      n = 0;
      c = clkO;
      while (clkO === c && n < 600) begin
         @(posedge sys_clk);
         n++;
      end
      c = clkO;
      n = 0;
      while (clkO === c && n < 600) begin
         @(posedge sys_clk);
         n++;
      end
      chk(n, e);
   endtask : half
   task wrc(input logic [31:0] d);
      apb(1'b1, `REG_CTRL, d, 34'h0);
      repeat (3) @(posedge sys_clk);
   endtask : wrc
   // Results are taken at the edge that sees ready
   always @(posedge sys_clk) if (apbRsp.pready === 1'b1) begin
      ex = expQ.pop_front();
      chk(apbRsp.pslverr, ex[32]);
      if (ex[33]) chk(apbRsp.prdata, ex[31:0]);
   end
   initial begin
      logic [2:0] m;
      logic [7:0] dv;
      logic ms;
      void'($urandom(27));
      for (int i = 0; i < 8; i++) begin
         // Code 3 stands for undriven pins, which pull up to slave serial
         m = (i == 3) ? 3'h7 : i[2:0];
         ms = m inside {3'h0, 3'h1, 3'h2, 3'h4};
         dv = $urandom;
         rst_b <= 1'b0;
         modePins <= m;
         repeat (10) @(posedge sys_clk);
         rst_b <= 1'b1;
         repeat (6) @(posedge sys_clk);
         apb(1'b0, `REG_CTRL, 0, {2'b10, `CTRL_RESET});
         apb(1'b0, `REG_STATUS, 0, {2'b10, 26'h0, 2'b00, m == 3'h7, m});
         apb(1'b0, 12'h00C, 0, {2'b11, 32'h0});
         chk(clkOe, ms);
         chk(selOe, m inside {3'h1, 3'h2});
         chk({sdoEn, dceEn, revEn}, 0);
         chk({bsEn, dpEn}, 3);
         dirLevel <= 1'($urandom);
         {coreSer, coreFs, coreNs} <= 3'($urandom);
         repeat (6) @(posedge sys_clk);
         chk(rwDir, m inside {3'h4, 3'h6} ? dirLevel : 1'b0);
         chk(sdo, coreSer);
         chk(dce, coreNs);
         chk(selO, coreFs);
         wrc({16'h0, dv, 8'h10});
         apb(1'b0, `REG_CTRL, 0, {2'b10, 16'h0, dv, 8'h10});
         chk(sdoEn, m inside {3'h0, 3'h1, 3'h7});
         chk(dceEn, m inside {3'h2, 3'h4, 3'h6});
         half(dv + 1);
         wrc(32'h0000_0004);
         chk(sdoEn, m inside {3'h0, 3'h1, 3'h7});
         wrc(32'h0000_0002);
         extRun <= ms;
         chk(extSel, ms);
         revisionValue <= $urandom;
         fallbackEvent <= 1'b1;
         @(posedge sys_clk);
         fallbackEvent <= 1'b0;
         repeat (3) @(posedge sys_clk);
         chk(revEn, 1'b0);
         reloadStart <= 1'b1;
         @(posedge sys_clk);
         reloadStart <= 1'b0;
         repeat (3) @(posedge sys_clk);
         chk(revEn, m == 3'h2);
         if (m == 3'h2) chk(revSel, revisionValue);
         repeat (40) @(posedge sys_clk);
         wrc(32'h0000_0008);
         fallbackEvent <= 1'b1;
         @(posedge sys_clk);
         fallbackEvent <= 1'b0;
         repeat (3) @(posedge sys_clk);
         chk(revEn, m == 3'h2);
         repeat (40) @(posedge sys_clk);
         extRun <= 1'b0;
         wrc(32'h0000_0021);
         chk(selOe, m inside {3'h1, 3'h2});
         wrc(32'h0000_0020);
         chk(selOe, 1'b0);
      end
      results();
   end
endmodule : config_pin_mode_mux_tb
bind config_pin_mode_mux cfg_pin_monitor MON (.sys_clk(sys_clk), .rst_b(rst_b), .apbReq(apbReq),
   .apbRsp(apbRsp), .serialDataOutEn(serialDataOutEn), .downstreamChipEnableEn(downstreamChipEnableEn),
   .revisionSelectEn(revisionSelectEn), .rdwr_or_flash_select_n_oe(rdwr_or_flash_select_n_oe),
   .read_write_dir_n(read_write_dir_n), .boundaryScanEnable(boundaryScanEnable),
   .dedicatedPinsEnable(dedicatedPinsEnable), .pinUse(pinUse));
